// [hdl/sld_driver.v]
// Serial shift register, output latch, blanking and cascade output of the display driver.
`timescale 1ns/1ps
`include "sld_map.vh"
module sld_driver (
    // System clock and synchronous reset
    input wire clk,
    input wire rst,
    // Serial link pins, asynchronous to clk
    input wire serial_clk,
    input wire serial_in,
    input wire load,
    input wire blank,
    // Cascade output
    output wire serial_out,
    // Display outputs, push-pull
    output wire [11:0] driver_outputs,
    // Captured-word stream out of the two-entry buffer
    output wire [11:0] word_data,
    output wire word_valid,
    input wire word_ready,
    // Buffer can accept the next capture
    output wire capture_ready,
    // Serial clock rises seen since the last capture, saturating
    output wire [7:0] shift_count,
    // Last capture followed a whole number of words
    output wire word_aligned
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers

wire sclk_s;
wire sin_s;
wire load_s;
wire blank_s;

// All four pins cross into clk before any logic reads them
sld_sync u_sync_sclk (
    .clk(clk),
    .rst(rst),
    .async_in(serial_clk),
    .sync_out(sclk_s)
);

sld_sync u_sync_sin (
    .clk(clk),
    .rst(rst),
    .async_in(serial_in),
    .sync_out(sin_s)
);

sld_sync u_sync_load (
    .clk(clk),
    .rst(rst),
    .async_in(load),
    .sync_out(load_s)
);

sld_sync u_sync_blank (
    .clk(clk),
    .rst(rst),
    .async_in(blank),
    .sync_out(blank_s)
);

////////////////////////////////////////////////////////////////////////////////
// Edge detection on the synchronised link clock and load

reg sclk_prev_q;
reg load_prev_q;
wire sclk_rise;
wire sclk_fall;
wire load_fall;

// Previous levels reset to the pins' idle low level, so an idle link shows no
// edge after reset; a pin held high across reset gives one edge as it settles
always @(posedge clk) begin
    if (rst) begin
        sclk_prev_q <= `SLD_BIT_ZERO;
        load_prev_q <= `SLD_BIT_ZERO;
    end else begin
        sclk_prev_q <= sclk_s;
        load_prev_q <= load_s;
    end
end

// Data and clock share the same synchroniser depth, so data is sampled at the
// same skew as the clock edge; the controller's hold time covers the skew
assign sclk_rise = sclk_s & ~sclk_prev_q;
assign sclk_fall = ~sclk_s & sclk_prev_q;
assign load_fall = ~load_s & load_prev_q;

////////////////////////////////////////////////////////////////////////////////
// Shift register

reg [`SLD_WORD_MSB:0] shift_q;
reg [`SLD_WORD_MSB:0] shift_d;

// First bit in ends at the top after twelve rises, so MSB-first words land
// with word bit n at index n
always @* begin
    shift_d = shift_q;
    if (sclk_rise) begin
        shift_d = {shift_q[`SLD_WORD_MSB-1:0], sin_s};
    end
end

// Shifts regardless of load or blank
always @(posedge clk) begin
    if (rst) begin
        shift_q <= `SLD_WORD_ZERO;
    end else begin
        shift_q <= shift_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Cascade output

reg sout_q;

// Last stage moves to the pin on the falling clock edge, half a period after
// the shift; a twelve-stage chain gives a twelve-clock pass-through delay
always @(posedge clk) begin
    if (rst) begin
        sout_q <= `SLD_BIT_ZERO;
    end else if (sclk_fall) begin
        sout_q <= shift_q[`SLD_WORD_MSB];
    end
end

assign serial_out = sout_q;

////////////////////////////////////////////////////////////////////////////////
// Output latch

reg [`SLD_WORD_MSB:0] latch_q;
reg [`SLD_WORD_MSB:0] latch_d;

// Transparent while load is high; the value seen at the falling edge stays.
// Follows shift_d while high; on a load fall it takes shift_q, so a shift in that same cycle loses the new bit.
always @* begin
    latch_d = latch_q;
    if (load_s) begin
        latch_d = shift_d;
    end else if (load_fall) begin
        latch_d = shift_q;
    end
end

// Blank is not an input here, so blanking never disturbs the latch
always @(posedge clk) begin
    if (rst) begin
        latch_q <= `SLD_WORD_ZERO;
    end else begin
        latch_q <= latch_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Driver outputs

reg [`SLD_WORD_MSB:0] outs_q;

// Registered gating of the latch by blank; one clk of extra latency is far
// below the output slew times of a real tube driver
always @(posedge clk) begin
    if (rst) begin
        outs_q <= `SLD_WORD_ZERO;
    end else if (blank_s) begin
        outs_q <= `SLD_WORD_ZERO;
    end else begin
        outs_q <= latch_q;
    end
end

assign driver_outputs = outs_q;

////////////////////////////////////////////////////////////////////////////////
// Shift counter and word alignment

reg [`SLD_SCNT_W-1:0] scnt_q;
reg [`SLD_MOD_W-1:0] mod_q;
reg aligned_q;
reg trk_state_q;

localparam TRK_IDLE = `SLD_ST_IDLE;
localparam TRK_OPEN = `SLD_ST_OPEN;

// Counts rises since the last capture and their position within a word, so
// software can see whether a cascade was clocked a whole number of words
always @(posedge clk) begin
    if (rst) begin
        scnt_q <= `SLD_SCNT_ZERO;
        mod_q <= `SLD_MOD_ZERO;
        aligned_q <= `SLD_BIT_ZERO;
        trk_state_q <= TRK_IDLE;
    end else begin
        case (trk_state_q)
            TRK_IDLE: begin
                if (sclk_rise) begin
                    trk_state_q <= TRK_OPEN;
                    scnt_q <= `SLD_SCNT_ONE;
                    mod_q <= `SLD_MOD_ONE;
                end
            end
            TRK_OPEN: begin
                if (load_fall) begin
                    aligned_q <= (mod_q == `SLD_MOD_ZERO);
                    trk_state_q <= TRK_IDLE;
                    scnt_q <= `SLD_SCNT_ZERO;
                end else if (sclk_rise) begin
                    if (scnt_q != `SLD_SCNT_MAX) begin
                        scnt_q <= scnt_q + `SLD_SCNT_ONE;
                    end
                    if (mod_q == `SLD_MOD_LAST) begin
                        mod_q <= `SLD_MOD_ZERO;
                    end else begin
                        mod_q <= mod_q + `SLD_MOD_ONE;
                    end
                end
            end
            default: begin
                trk_state_q <= TRK_IDLE;
            end
        endcase
    end
end

assign shift_count = scnt_q;
assign word_aligned = aligned_q;

////////////////////////////////////////////////////////////////////////////////
// Two-entry capture buffer

reg [`SLD_WORD_MSB:0] buf0_q;
reg [`SLD_WORD_MSB:0] buf1_q;
reg wr_ptr_q;
reg rd_ptr_q;
reg [`SLD_CNT_W-1:0] cnt_q;
wire buf_push;
wire buf_pop;
wire buf_full;
wire buf_empty;

// The pins cannot be stalled, so the limitation is plain: a capture that meets
// a full buffer is not stored; capture_ready tells the source beforehand
assign buf_full = (cnt_q == `SLD_CNT_FULL);
assign buf_empty = (cnt_q == `SLD_CNT_ZERO);
assign capture_ready = ~buf_full;
assign buf_push = load_fall & ~buf_full;
assign buf_pop = word_valid & word_ready;

// Storage and write pointer
always @(posedge clk) begin
    if (rst) begin
        buf0_q <= `SLD_WORD_ZERO;
        buf1_q <= `SLD_WORD_ZERO;
        wr_ptr_q <= `SLD_BIT_ZERO;
    end else if (buf_push) begin
        if (wr_ptr_q) begin
            buf1_q <= shift_q;
        end else begin
            buf0_q <= shift_q;
        end
        wr_ptr_q <= ~wr_ptr_q;
    end
end

// Read pointer and fill count; push and pop together leave the count alone
always @(posedge clk) begin
    if (rst) begin
        rd_ptr_q <= `SLD_BIT_ZERO;
        cnt_q <= `SLD_CNT_ZERO;
    end else begin
        if (buf_pop) begin
            rd_ptr_q <= ~rd_ptr_q;
        end
        if (buf_push & ~buf_pop) begin
            cnt_q <= cnt_q + `SLD_CNT_ONE;
        end else if (buf_pop & ~buf_push) begin
            cnt_q <= cnt_q - `SLD_CNT_ONE;
        end
    end
end

assign word_valid = ~buf_empty;
assign word_data = rd_ptr_q ? buf1_q : buf0_q;

endmodule // sld_driver

// [hdl/sld_map.vh]
// Constants of the serial latch display driver: widths, reset values, buffer layout.
`ifndef SLD_MAP_VH
`define SLD_MAP_VH

// Serial word
`define SLD_WORD_BITS 12
`define SLD_WORD_MSB 11
`define SLD_WORD_ZERO 12'h000
`define SLD_BIT_ZERO 1'b0
`define SLD_BIT_ONE 1'b1

// Two-entry word buffer
`define SLD_BUF_DEPTH 2
`define SLD_CNT_W 2
`define SLD_CNT_ZERO 2'h0
`define SLD_CNT_ONE 2'h1
`define SLD_CNT_FULL 2'h2

// Shift counter since the last capture, saturating
`define SLD_SCNT_W 8
`define SLD_SCNT_ZERO 8'h00
`define SLD_SCNT_ONE 8'h01
`define SLD_SCNT_MAX 8'hFF

// Position of the next rise within a word, wraps after the last bit
`define SLD_MOD_W 4
`define SLD_MOD_ZERO 4'h0
`define SLD_MOD_ONE 4'h1
`define SLD_MOD_LAST 4'hB

// Capture tracker states
`define SLD_ST_IDLE 1'b0
`define SLD_ST_OPEN 1'b1

`endif

// [hdl/sld_sync.v]
// Two flip-flop synchroniser for one input that comes from outside the clock domain.
`timescale 1ns/1ps
`include "sld_map.vh"
module sld_sync (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Asynchronous level in, synchronised level out
    input wire async_in,
    output wire sync_out
);

reg stage1_q;
reg stage2_q;

// First stage is read only by the second stage
always @(posedge clk) begin
    if (rst) begin
        stage1_q <= `SLD_BIT_ZERO;
        stage2_q <= `SLD_BIT_ZERO;
    end else begin
        stage1_q <= async_in;
        stage2_q <= stage1_q;
    end
end

assign sync_out = stage2_q;

endmodule // sld_sync

// [tb/sld_driver_props.sv]
// Port assertions for the display driver.
`timescale 1ns/1ps
module sld_driver_props (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Link pins
    input wire serial_clk,
    input wire serial_in,
    input wire load,
    input wire blank,
    // Driver outputs
    input wire serial_out,
    input wire [11:0] driver_outputs,
    // Capture buffer and observation
    input wire [11:0] word_data,
    input wire word_valid,
    input wire word_ready,
    input wire capture_ready,
    input wire [7:0] shift_count,
    input wire word_aligned
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    reset_clear_a: assert property (
        disable iff (1'b0) rst |=> driver_outputs == 12'h000 && !serial_out && !word_valid)
        else $error("outputs not clear after reset");
    blank_forces_a: assert property (
        blank [*5] |-> driver_outputs == 12'h000) else $error("blank did not force low");
    latch_hold_a: assert property (
        (!load && !blank) [*7] |-> $stable(driver_outputs)) else $error("latch moved");
    buf_hold_a: assert property (
        word_valid && !word_ready |=> word_valid && $stable(word_data)) else $error("buffer lost");
    full_valid_a: assert property (
        !capture_ready |-> word_valid) else $error("full buffer shows no word");
    count_step_a: assert property (
        $changed(shift_count) && shift_count != 8'h00 |-> shift_count == $past(shift_count) + 8'h01)
        else $error("shift count jumped");
    sout_fall_a: assert property (
        $changed(serial_out) |-> !$past(serial_clk, 1) && !$past(serial_clk, 2))
        else $error("serial out moved off a falling clock");
    capture_match_a: assert property (
        $rose(word_valid) && !blank |-> word_data == driver_outputs)
        else $error("captured word differs from outputs");
endmodule // sld_driver_props

bind sld_driver sld_driver_props u_props (.clk(clk), .rst(rst), .serial_clk(serial_clk),
    .serial_in(serial_in), .load(load), .blank(blank), .serial_out(serial_out),
    .driver_outputs(driver_outputs), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .capture_ready(capture_ready), .shift_count(shift_count),
    .word_aligned(word_aligned));

// [tb/sld_link_model.sv]
// Controller model driving the serial link of the display driver.
`timescale 1ns/1ps
module sld_link_model (
    // Time base
    input wire clk,
    // Link pins toward the driver
    output logic serial_clk,
    output logic serial_in,
    output logic load,
    // Cascade pin from the driver
    input wire serial_out
);
    logic [11:0] cascade_seen;
    ////////////////////////////////////////////////////////////
    // Link clock rests low between frames
    initial begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        load = 1'b0;
        cascade_seen = 12'h000;
    end
    // The low n bits of w, top bit first, 160 ns clock; data held well past each rise
    task automatic send_bits(input logic [11:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk);
            serial_in = w[i];
            repeat (4) @(negedge clk);
            cascade_seen = {cascade_seen[10:0], serial_out};
            serial_clk = 1'b1;
            repeat (8) @(negedge clk);
            serial_clk = 1'b0;
            repeat (3) @(negedge clk);
        end
        // Released data line shows the inverse, not a stale copy
        serial_in = ~w[0];
    endtask
    // One whole word
    task automatic send_word(input logic [11:0] w);
        send_bits(w, 12);
    endtask
    // Load level change, then settle time for the capture
    task automatic set_load(input logic v);
        @(negedge clk);
        load = v;
        repeat (8) @(negedge clk);
    endtask
    task automatic pulse_load();
        set_load(1'b1);
        set_load(1'b0);
    endtask
endmodule // sld_link_model

// [tb/tb_sld_driver.sv]
// Self-checking bench for the display driver.
`timescale 1ns/1ps
module tb_sld_driver;
    logic clk, rst, blank, word_ready;
    wire serial_clk, serial_in, load, serial_out, word_valid, capture_ready, word_aligned;
    wire [11:0] driver_outputs, word_data;
    wire [7:0] shift_count;
    int miscompares = 0, comparisons = 0, cycles = 0;
    sld_driver u_dut (.clk(clk), .rst(rst), .serial_clk(serial_clk), .serial_in(serial_in),
        .load(load), .blank(blank), .serial_out(serial_out), .driver_outputs(driver_outputs),
        .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
        .capture_ready(capture_ready), .shift_count(shift_count), .word_aligned(word_aligned));
    sld_link_model u_link (.clk(clk), .serial_clk(serial_clk), .serial_in(serial_in),
        .load(load), .serial_out(serial_out));
    ////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pop one word, sink ready for exactly one edge
    task pop(input logic [11:0] exp);
        @(negedge clk);
        chk(word_valid, 1'b1);
        chk(word_data, exp);
        word_ready = 1'b1;
        @(negedge clk);
        word_ready = 1'b0;
    endtask
    task tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Scenarios
    task t_word();
        u_link.send_word(12'hA5C);
        chk(driver_outputs, 12'h000);
        u_link.pulse_load();
        chk(driver_outputs, 12'hA5C);
        chk({shift_count, word_aligned}, 9'h001);
        pop(12'hA5C);
        $display("test word done");
    endtask
    task t_blank();
        blank = 1'b1;
        u_link.send_word(12'h3F1);
        u_link.pulse_load();
        chk(driver_outputs, 12'h000);
        @(negedge clk) blank = 1'b0;
        repeat (5) @(negedge clk);
        chk(driver_outputs, 12'h3F1);
        $display("test blank done");
    endtask
    task t_follow();
        u_link.set_load(1'b1);
        u_link.send_word(12'h0C3);
        repeat (5) @(negedge clk);
        chk(driver_outputs, 12'h0C3);
        u_link.set_load(1'b0);
        $display("test transparent done");
    endtask
    task t_full();
        chk(capture_ready, 1'b0);
        u_link.pulse_load();
        pop(12'h3F1);
        pop(12'h0C3);
        @(negedge clk);
        chk({word_valid, capture_ready}, 2'b01);
        $display("test buffer done");
    endtask
    task t_chain();
        u_link.send_word(12'h5A6);
        u_link.send_word(12'h93E);
        chk(u_link.cascade_seen, 12'h5A6);
        chk(shift_count, 8'h18);
        chk(driver_outputs, 12'h0C3);
        u_link.pulse_load();
        chk(driver_outputs, 12'h93E);
        chk({shift_count, word_aligned}, 9'h001);
        pop(12'h93E);
        $display("test cascade done");
    endtask
    // Part word leaves the capture unaligned; a long run saturates the count
    task t_align();
        u_link.send_bits(12'h016, 5);
        chk(shift_count, 8'h05);
        u_link.pulse_load();
        chk(driver_outputs, 12'h7D6);
        chk({shift_count, word_aligned}, 9'h000);
        pop(12'h7D6);
        repeat (22) u_link.send_word(12'h000);
        chk(shift_count, 8'hFF);
        u_link.pulse_load();
        chk(driver_outputs, 12'h000);
        chk({shift_count, word_aligned}, 9'h001);
        pop(12'h000);
        $display("test alignment done");
    endtask
    // Main sequence; blank held high through reset, link pins low
    initial begin
        rst = 1'b1;
        blank = 1'b1;
        word_ready = 1'b0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        blank = 1'b0;
        repeat (5) @(negedge clk);
        chk({driver_outputs, serial_out}, 13'h0000);
        chk({word_valid, capture_ready}, 2'b01);
        $display("test reset done");
        t_word();
        t_blank();
        t_follow();
        t_full();
        t_chain();
        t_align();
        tally_and_finish();
    end
endmodule // tb_sld_driver
